// [core/port3_mux_params.svh]
// Constants for the port three function steering block.
`ifndef PORT3_MUX_PARAMS_SVH
`define PORT3_MUX_PARAMS_SVH
`define REG_OUT_LATCH    12'h000
`define REG_IN_LEVEL     12'h004
`define REG_FUNC_CFG     12'h008
`define REG_TIMER_CFG    12'h00c
`define REG_T0_RELOAD    12'h010
`define REG_T1_RELOAD    12'h014
`define REG_T0_COUNT     12'h018
`define REG_T1_COUNT     12'h01c
`define REG_IRQ_STATUS   12'h020
`define REG_IRQ_MASK     12'h024
`define REG_HS_CTRL      12'h028
`define CFG_SERIAL       0
`define CFG_IRQ_EN       1
`define CFG_HS0          2
`define CFG_HS1          3
`define CFG_HS2          4
`define CFG_DMEM         5
`define CFG_TOUT_EN      6
`define CFG_TOUT_SEL     9:8
`define CFG_TIN_SEL      11:10
`define CFG_P2_TOP_OUT   12
`define TCFG_T0_EN       0
`define TCFG_T1_EN       1
`define TCFG_T1_EXT      2
`define TCFG_T0_PRE      13:8
`define TCFG_T1_PRE      21:16
`define IRQ_BITS         6
`define FUNC_CFG_W       13
`define TIMER_CFG_W      22
`define HS_CTRL_W        3
`define ZERO_WORD        32'h0000_0000
`endif

// [core/port3_mux_pkg.sv]
// Types shared by the port three function steering block.
package port3_mux_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [5:0] pre_type;
endpackage : port3_mux_pkg

// [core/prescaled_timer.sv]
// One 8-bit counter with a 6-bit prescaler, reloading and flagging on terminal count.
`timescale 1ns/1ps
`include "port3_mux_params.svh"
module prescaled_timer (
  // Clock and reset.
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // Control.
  input  wire logic                        enable,
  input  wire logic                        tick,
  input  wire port3_mux_pkg::pre_type      prescale,
  input  wire port3_mux_pkg::byte_type     reload,
  // Status.
  output logic      [7:0]                  count,
  output logic                             done
);
  import port3_mux_pkg::*;

  typedef struct packed {
    pre_type  pre;
    byte_type cnt;
    logic     done;
  } state_type;

  state_type state_ff;
  state_type nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    if (!enable) begin
      nxt_state.pre = prescale;
      nxt_state.cnt = reload;
    end else if (tick) begin
      // A prescale of zero divides by one, the same as one, so no setting stalls the counter.
      if (state_ff.pre == 6'h01 || state_ff.pre == 6'h00) begin
        nxt_state.pre = prescale;
        if (state_ff.cnt == 8'h01 || state_ff.cnt == 8'h00) begin
          nxt_state.cnt  = reload;
          nxt_state.done = 1'b1;
        end else begin
          nxt_state.cnt = state_ff.cnt - 8'h01;
        end
      end else begin
        nxt_state.pre = state_ff.pre - 6'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign count = state_ff.cnt;
  assign done  = state_ff.done;
endmodule : prescaled_timer

// [core/port3_function_mux.sv]
// Port three line steering with timers, interrupt capture and an APB register file.
`timescale 1ns/1ps
`include "port3_mux_params.svh"
module port3_function_mux (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port pins.
  input  wire port3_mux_pkg::byte_type fixed_input_lines,
  output logic      [3:0]  fixed_output_lines,
  // Function side.
  input  wire logic        serial_tx_data,
  output logic             serial_rx_data,
  input  wire logic        data_memory_select,
  input  wire logic        port2_top_bit,
  output logic      [3:0]  external_irq_lines,
  output logic      [2:0]  hs_in_level,
  output logic             prog_chip_enable_n,
  output logic             prog_output_enable_n,
  output logic             prog_mode_select,
  output logic             prog_voltage,
  // Interrupt.
  output logic             irq
);
  import port3_mux_pkg::*;

  typedef struct packed {
    logic [31:0]              rdata;
    logic                     ready;
    logic                     slverr;
    logic [3:0]               out_latch;
    logic [`FUNC_CFG_W-1:0]   func_cfg;
    logic [`TIMER_CFG_W-1:0]  timer_cfg;
    byte_type                 t0_reload;
    byte_type                 t1_reload;
    logic [`IRQ_BITS-1:0]     irq_status;
    logic [`IRQ_BITS-1:0]     irq_mask;
    logic [`HS_CTRL_W-1:0]    hs_ready;
    logic [3:0]               in_prev;
    logic                     tin_prev;
    logic                     tout;
    logic [3:0]               pins_out;
    logic                     rx;
    logic [3:0]               irq_lines;
    logic [2:0]               hs_in;
    logic [3:0]               prog;
    logic                     irq;
  } state_type;

  state_type state_ff;
  state_type nxt_state;

  logic [7:0] t0_count;
  logic [7:0] t1_count;
  logic       t0_done;
  logic       t1_done;
  logic       tin_level;
  logic       tin_rise;
  logic       t1_tick;

  // Picks one input line by a two-bit index.
  function automatic logic pick4(input logic [3:0] v, input logic [1:0] i);
    pick4 = v[i];
  endfunction : pick4

  assign tin_level = pick4(fixed_input_lines[3:0], state_ff.func_cfg[`CFG_TIN_SEL]);
  assign tin_rise  = tin_level & ~state_ff.tin_prev;
  // Timer one counts either every clock or each rising edge of the timer input.
  assign t1_tick   = state_ff.timer_cfg[`TCFG_T1_EXT] ? tin_rise : 1'b1;

  prescaled_timer u_timer0 (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (state_ff.timer_cfg[`TCFG_T0_EN]),
    .tick     (1'b1),
    .prescale (state_ff.timer_cfg[`TCFG_T0_PRE]),
    .reload   (state_ff.t0_reload),
    .count    (t0_count),
    .done     (t0_done)
  );

  prescaled_timer u_timer1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (state_ff.timer_cfg[`TCFG_T1_EN]),
    .tick     (t1_tick),
    .prescale (state_ff.timer_cfg[`TCFG_T1_PRE]),
    .reload   (state_ff.t1_reload),
    .count    (t1_count),
    .done     (t1_done)
  );

  always_comb begin
    logic                 wr;
    logic                 rd;
    logic [3:0]           in_fall;
    logic [`IRQ_BITS-1:0] events;
    logic [3:0]           outs;
    logic                 p2_out;
    logic [31:0]          rv;
    wr      = 1'b0;
    rd      = 1'b0;
    in_fall = 4'h0;
    events  = '0;
    outs    = 4'h0;
    p2_out  = 1'b0;
    rv      = `ZERO_WORD;
    nxt_state = state_ff;
    nxt_state.ready  = 1'b0;
    nxt_state.slverr = 1'b0;
    wr = psel && penable && !state_ff.ready && pwrite;
    rd = psel && penable && !state_ff.ready && !pwrite;

    // Interrupt requests are taken on falling input edges, mapped as in the pin table.
    in_fall = state_ff.in_prev & ~fixed_input_lines[3:0];
    if (state_ff.func_cfg[`CFG_IRQ_EN]) begin
      events[3] = in_fall[0];
      events[2] = in_fall[1];
      events[0] = in_fall[2];
      events[1] = in_fall[3];
    end
    events[4] = t0_done;
    events[5] = t1_done;

    if (wr) begin
      case (paddr)
        `REG_OUT_LATCH:  nxt_state.out_latch = pwdata[3:0];
        `REG_FUNC_CFG:   nxt_state.func_cfg = pwdata[`FUNC_CFG_W-1:0];
        `REG_TIMER_CFG:  nxt_state.timer_cfg = pwdata[`TIMER_CFG_W-1:0];
        `REG_T0_RELOAD:  nxt_state.t0_reload = pwdata[7:0];
        `REG_T1_RELOAD:  nxt_state.t1_reload = pwdata[7:0];
        `REG_IRQ_MASK:   nxt_state.irq_mask = pwdata[`IRQ_BITS-1:0];
        `REG_HS_CTRL:    nxt_state.hs_ready = pwdata[`HS_CTRL_W-1:0];
        `REG_IRQ_STATUS: nxt_state.irq_status = state_ff.irq_status & ~pwdata[`IRQ_BITS-1:0];
        `REG_IN_LEVEL, `REG_T0_COUNT, `REG_T1_COUNT: nxt_state.slverr = 1'b0;
        default:         nxt_state.slverr = 1'b1;
      endcase
    end
    // Setting after clearing lets an event in the clearing cycle survive.
    nxt_state.irq_status = nxt_state.irq_status | events;

    if (rd) begin
      case (paddr)
        `REG_OUT_LATCH:  rv[3:0] = state_ff.out_latch;
        `REG_IN_LEVEL:   rv[7:0] = fixed_input_lines;
        `REG_FUNC_CFG:   rv[`FUNC_CFG_W-1:0] = state_ff.func_cfg;
        `REG_TIMER_CFG:  rv[`TIMER_CFG_W-1:0] = state_ff.timer_cfg;
        `REG_T0_RELOAD:  rv[7:0] = state_ff.t0_reload;
        `REG_T1_RELOAD:  rv[7:0] = state_ff.t1_reload;
        `REG_T0_COUNT:   rv[7:0] = t0_count;
        `REG_T1_COUNT:   rv[7:0] = t1_count;
        `REG_IRQ_STATUS: rv[`IRQ_BITS-1:0] = state_ff.irq_status;
        `REG_IRQ_MASK:   rv[`IRQ_BITS-1:0] = state_ff.irq_mask;
        `REG_HS_CTRL:    rv[`HS_CTRL_W-1:0] = state_ff.hs_ready;
        default:         nxt_state.slverr = 1'b1;
      endcase
      nxt_state.rdata = rv;
    end
    nxt_state.ready = wr || rd;

    // Timer output toggles on each timer zero terminal count.
    if (!state_ff.func_cfg[`CFG_TOUT_EN]) begin
      nxt_state.tout = 1'b0;
    end else if (t0_done) begin
      nxt_state.tout = ~state_ff.tout;
    end

    // Output steering: latch by default, enabled functions take their lines; data memory beats HS1 on line 0, timer output beats all.
    outs = state_ff.out_latch;
    p2_out = state_ff.func_cfg[`CFG_P2_TOP_OUT];
    if (state_ff.func_cfg[`CFG_HS1]) begin
      outs[0] = state_ff.hs_ready[1];
    end
    if (state_ff.func_cfg[`CFG_DMEM]) begin
      outs[0] = data_memory_select;
    end
    if (state_ff.func_cfg[`CFG_HS0]) begin
      outs[1] = state_ff.hs_ready[0];
    end
    if (state_ff.func_cfg[`CFG_HS2]) begin
      // The port two output line carries the strobe or ready by its top-bit direction.
      outs[2] = p2_out ? port2_top_bit : state_ff.hs_ready[2];
    end
    if (state_ff.func_cfg[`CFG_SERIAL]) begin
      outs[3] = serial_tx_data;
    end
    if (state_ff.func_cfg[`CFG_TOUT_EN]) begin
      outs[state_ff.func_cfg[`CFG_TOUT_SEL]] = state_ff.tout;
    end
    nxt_state.pins_out = outs;

    nxt_state.rx = state_ff.func_cfg[`CFG_SERIAL] ? fixed_input_lines[0] : 1'b1;
    nxt_state.irq_lines = {fixed_input_lines[0], fixed_input_lines[1],
                           fixed_input_lines[3], fixed_input_lines[2]};
    nxt_state.hs_in = {fixed_input_lines[1], fixed_input_lines[3], fixed_input_lines[2]};
    // Programming strobes are only observed; the programmer owns these levels.
    nxt_state.prog = fixed_input_lines[3:0];
    nxt_state.in_prev = fixed_input_lines[3:0];
    nxt_state.tin_prev = tin_level;
    nxt_state.irq = |(state_ff.irq_status & state_ff.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata               = state_ff.rdata;
  assign pready               = state_ff.ready;
  assign pslverr              = state_ff.slverr;
  assign fixed_output_lines   = state_ff.pins_out;
  assign serial_rx_data       = state_ff.rx;
  assign external_irq_lines   = state_ff.irq_lines;
  assign hs_in_level          = state_ff.hs_in;
  assign prog_chip_enable_n   = state_ff.prog[0];
  assign prog_output_enable_n = state_ff.prog[1];
  assign prog_mode_select     = state_ff.prog[2];
  assign prog_voltage         = state_ff.prog[3];
  assign irq                  = state_ff.irq;
endmodule : port3_function_mux

// [verif/port3_mux_checker_assertions.sv]
// Port checks for the port three function steering block.
`timescale 1ns/1ps
module port3_mux_checker (
  // Clock and reset.
  input wire logic                    pclk,
  input wire logic                    presetn,
  // APB handshake.
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // Pins and function side.
  input wire port3_mux_pkg::byte_type fixed_input_lines,
  input wire logic                    serial_rx_data,
  input wire logic [3:0]              external_irq_lines,
  input wire logic [2:0]              hs_in_level,
  input wire logic                    prog_chip_enable_n,
  input wire logic                    prog_output_enable_n,
  input wire logic                    prog_mode_select,
  input wire logic                    prog_voltage,
  input wire logic                    irq
);
  import port3_mux_pkg::*;
  byte_type fin;
  assign fin = fixed_input_lines;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pin paths are judged only after the first sample following reset has landed.
  irq_route_a: assert property ($past(presetn, 3) |-> external_irq_lines ==
    {$past(fin[0]), $past(fin[1]), $past(fin[3]), $past(fin[2])})
    else $error("request lines do not follow the inputs");
  hs_route_a: assert property ($past(presetn, 3) |->
    hs_in_level == {$past(fin[1]), $past(fin[3]), $past(fin[2])})
    else $error("handshake inputs misrouted");
  prog_route_a: assert property ($past(presetn, 3) |-> {prog_voltage,
    prog_mode_select, prog_output_enable_n, prog_chip_enable_n} == $past(fin[3:0]))
    else $error("programming strobes misrouted");
  rx_route_a: assert property ($past(presetn, 3) && !serial_rx_data |->
    !$past(fin[0]))
    else $error("receive data low without a low input");
  take_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after a taken access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error flagged without ready");
  ready_cause_a: assert property (pready |-> $past(psel && penable && !pready))
    else $error("ready without a taken access");
  cover property (pslverr);
  cover property (irq);
  cover property ($fell(serial_rx_data));
endmodule : port3_mux_checker

bind port3_function_mux port3_mux_checker i_port3_mux_checker (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .fixed_input_lines, .serial_rx_data, .external_irq_lines,
  .hs_in_level, .prog_chip_enable_n, .prog_output_enable_n, .prog_mode_select,
  .prog_voltage, .irq);

// [verif/pin_partner.sv]
// Far-side model of the peripherals and programmer that drive the input pins.
`timescale 1ns/1ps
module pin_partner (
  // Clock.
  input  wire logic       pclk,
  // Commanded levels.
  input  wire logic [3:0] want,
  // Pins.
  output logic      [7:0] pins
);
  // The upper bits have no real driver, so they carry the inverse rather than a copy.
  always_ff @(posedge pclk) begin
    pins <= {~want, want};
  end
endmodule : pin_partner

// [verif/test_port3_function_mux.sv]
// Directed bench for the port three function steering block.
`timescale 1ns/1ps
`include "port3_mux_params.svh"
module test_port3_function_mux;
  import port3_mux_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, tx = 1, dms = 0, top = 0, rx, irq;
  logic [3:0]  want = 4'hf, outs, xirq, prog;
  logic [2:0]  hsin;
  logic [1:0]  seen;
  byte_type    pins;
  int          bad_count = 0, check_count = 0;
  int          hs_pos[3] = '{1, 0, 2};
  int          req_of[4] = '{3, 2, 0, 1};
  always #2 pclk = ~pclk;
  pin_partner i_pin_partner (.pclk, .want, .pins);
  port3_function_mux i_port3_function_mux (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .fixed_input_lines(pins),
    .fixed_output_lines(outs), .serial_tx_data(tx), .serial_rx_data(rx),
    .data_memory_select(dms), .port2_top_bit(top), .external_irq_lines(xirq),
    .hs_in_level(hsin), .prog_chip_enable_n(prog[0]), .prog_output_enable_n(prog[1]),
    .prog_mode_select(prog[2]), .prog_voltage(prog[3]), .irq);
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; it starts one edge later so no signal is driven twice in a step.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n == 50) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask : rdc
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask : settle
  task automatic pin(input logic [3:0] v);
    want <= v;
    settle();
  endtask : pin
  task automatic print_verdict();
    $display("bad_count %0d check_count %0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wr(`REG_OUT_LATCH, 32'h0000_000a);
    pin(4'h4);
    chk("latch", outs, 4'ha);
    rdc("levels", `REG_IN_LEVEL, 32'h0000_00b4);
    chk("rx idle", rx, 1'b1);
    wr(`REG_FUNC_CFG, 32'h1);
    tx <= 1'b0;
    settle();
    chk("tx", outs[3], 1'b0);
    chk("rx", rx, 1'b0);
    wr(`REG_OUT_LATCH, 32'h0);
    wr(`REG_FUNC_CFG, 32'h20);
    dms <= 1'b1;
    settle();
    chk("dmem", outs[0], 1'b1);
    wr(`REG_HS_CTRL, 32'h7);
    for (int i = 0; i < 3; i++) begin
      wr(`REG_FUNC_CFG, 32'h4 << i);
      settle();
      chk("ready", outs[hs_pos[i]], 1'b1);
    end
    wr(`REG_FUNC_CFG, 32'h1010);
    top <= 1'b1;
    settle();
    chk("strobe hi", outs[2], 1'b1);
    top <= 1'b0;
    settle();
    chk("strobe lo", outs[2], 1'b0);
    wr(`REG_IRQ_MASK, 32'h3f);
    wr(`REG_FUNC_CFG, 32'h2);
    for (int j = 0; j < 4; j++) begin
      pin(4'hf);
      pin(4'hf ^ (4'h1 << j));
      rdc("request", `REG_IRQ_STATUS, 32'h1 << req_of[j]);
      chk("irq", irq, 1'b1);
      wr(`REG_IRQ_STATUS, 32'h3f);
    end
    wr(`REG_IRQ_MASK, 32'h0);
    pin(4'hf);
    pin(4'he);
    chk("masked", irq, 1'b0);
    rdc("sticky", `REG_IRQ_STATUS, 32'h8);
    wr(`REG_IRQ_STATUS, 32'h3f);
    rdc("cleared", `REG_IRQ_STATUS, 32'h0);
    wr(`REG_T0_RELOAD, 32'h2);
    wr(`REG_T0_COUNT, 32'h55);
    rdc("count ro", `REG_T0_COUNT, 32'h2);
    wr(`REG_TIMER_CFG, 32'h101);
    for (int k = 0; k < 4; k++) begin
      wr(`REG_FUNC_CFG, 32'h40 | (k << 8));
      seen = 2'b00;
      repeat (16) begin
        @(posedge pclk);
        seen = seen | (outs[k] ? 2'b10 : 2'b01);
      end
      chk("tout", seen, 2'b11);
    end
    rdc("t0 done", `REG_IRQ_STATUS, 32'h10);
    wr(`REG_FUNC_CFG, 32'h0);
    wr(`REG_T1_RELOAD, 32'h3);
    wr(`REG_TIMER_CFG, 32'h10006);
    rdc("t1 held", `REG_T1_COUNT, 32'h3);
    for (int m = 0; m < 4; m++) pin(m[0] ? 4'hf : 4'he);
    bus(1'b0, `REG_T1_COUNT, 32'h0);
    chk("t1 ticks", rd, 32'h1);
    bus(1'b1, 12'h030, 32'h1);
    chk("unmapped", err, 1'b1);
    bus(1'b1, `REG_IN_LEVEL, 32'h1);
    chk("ro write", err, 1'b0);
    print_verdict();
  end
  // The directed run needs about 300 cycles; this leaves ample margin.
  initial begin
    #40000;
    bad_count++;
    print_verdict();
  end
endmodule : test_port3_function_mux
